// ### include/acu_consts.vh
// constants for the analog compare unit configuration and timing logic
`ifndef ACU_CONSTS_VH
`define ACU_CONSTS_VH

// register byte addresses on the peripheral bus
`define ACU_ADDR_W 24
`define ACU_OFS_CTRL_STATUS 24'h00fd40
`define ACU_OFS_CONFIG 24'h00fd42
`define ACU_OFS_TIMING 24'h00fd44

// reset values
`define ACU_CONFIG_RST 8'h00
`define ACU_TIMING_RST 8'h37
`define ACU_FLAGS_RST 3'h0
`define ACU_MODE_RST 2'h0

// writable bits; everything else is reserved and reads zero
`define ACU_CONFIG_WMASK 8'h3b
`define ACU_TIMING_WMASK 8'h37

// configuration fields
`define ACU_CFG_MODE_LSB 0
`define ACU_CFG_MODE_MSB 1
`define ACU_CFG_MEAS_IRQ_EN 3
`define ACU_CFG_THR_IRQ_EN 4
`define ACU_CFG_POLARITY 5

// timing fields
`define ACU_TIM_DELAY_LSB 0
`define ACU_TIM_DELAY_MSB 2
`define ACU_TIM_TRIGDIV_LSB 4
`define ACU_TIM_TRIGDIV_MSB 5

// control/status fields
`define ACU_CTS_START 0
`define ACU_CTS_EOM 1
`define ACU_CTS_EOC 2
`define ACU_CTS_THR 3

// operating mode encodings
`define ACU_MODE_OFF 2'h0
`define ACU_MODE_LEVEL_BURST 2'h1
`define ACU_MODE_THRESH_BURST 2'h2
`define ACU_MODE_LOW_POWER 2'h3

// settling periods in clock cycles, per sampling delay code
`define ACU_SETTLE_0 6'h01
`define ACU_SETTLE_1 6'h01
`define ACU_SETTLE_2 6'h02
`define ACU_SETTLE_3 6'h02
`define ACU_SETTLE_4 6'h02
`define ACU_SETTLE_5 6'h02
`define ACU_SETTLE_6 6'h03
`define ACU_SETTLE_7 6'h03

// compare periods in clock cycles, per sampling delay code
`define ACU_COMPARE_0 6'h0a
`define ACU_COMPARE_1 6'h0f
`define ACU_COMPARE_2 6'h14
`define ACU_COMPARE_3 6'h19
`define ACU_COMPARE_4 6'h1e
`define ACU_COMPARE_5 6'h23
`define ACU_COMPARE_6 6'h2d
`define ACU_COMPARE_7 6'h37

`endif

// ### rtl/acu_sample_timer.v
// sampling delay sequencer: settle then compare, then one capture strobe
`timescale 1ns/1ps
`include "acu_consts.vh"

module acu_sample_timer (
    // clock and reset
    input wire i_ref_clk,
    input wire i_rst_n,
    // control
    input wire i_run,
    input wire i_restart,
    input wire [2:0] i_delay_code,
    // result
    output reg o_capture
);

localparam [2:0] ST_IDLE = 3'h1;
localparam [2:0] ST_SETTLE = 3'h2;
localparam [2:0] ST_COMPARE = 3'h4;

reg [2:0] state_reg;
reg [2:0] state_next;
reg [5:0] count_reg;
reg [5:0] count_next;
reg capture_next;

// settle length for a delay code
function [5:0] settle_len;
    input [2:0] code;
    begin
        case (code)
            3'h0: settle_len = `ACU_SETTLE_0;
            3'h1: settle_len = `ACU_SETTLE_1;
            3'h2: settle_len = `ACU_SETTLE_2;
            3'h3: settle_len = `ACU_SETTLE_3;
            3'h4: settle_len = `ACU_SETTLE_4;
            3'h5: settle_len = `ACU_SETTLE_5;
            3'h6: settle_len = `ACU_SETTLE_6;
            default: settle_len = `ACU_SETTLE_7;
        endcase
    end
endfunction

// compare length for a delay code
function [5:0] compare_len;
    input [2:0] code;
    begin
        case (code)
            3'h0: compare_len = `ACU_COMPARE_0;
            3'h1: compare_len = `ACU_COMPARE_1;
            3'h2: compare_len = `ACU_COMPARE_2;
            3'h3: compare_len = `ACU_COMPARE_3;
            3'h4: compare_len = `ACU_COMPARE_4;
            3'h5: compare_len = `ACU_COMPARE_5;
            3'h6: compare_len = `ACU_COMPARE_6;
            default: compare_len = `ACU_COMPARE_7;
        endcase
    end
endfunction

// next state; a restart returns to idle, so a fresh settle period follows only while i_run stays high
always @* begin
    state_next = state_reg;
    count_next = count_reg;
    capture_next = 1'b0;
    case (state_reg)
        ST_IDLE: begin
            if (i_run) begin
                state_next = ST_SETTLE;
                count_next = settle_len(i_delay_code) - 6'h01;
            end
        end
        ST_SETTLE: begin
            if (count_reg == 6'h00) begin
                state_next = ST_COMPARE;
                count_next = compare_len(i_delay_code) - 6'h01;
            end else begin
                count_next = count_reg - 6'h01;
            end
        end
        ST_COMPARE: begin
            if (count_reg == 6'h00) begin
                capture_next = 1'b1;
                state_next = ST_IDLE;
            end else begin
                count_next = count_reg - 6'h01;
            end
        end
        default: begin
            state_next = ST_IDLE;
            count_next = 6'h00;
        end
    endcase
    if (!i_run || i_restart) begin
        state_next = ST_IDLE;
        count_next = 6'h00;
        capture_next = 1'b0;
    end
end

// state registers
always @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
        state_reg <= ST_IDLE;
        count_reg <= 6'h00;
        o_capture <= 1'b0;
    end else begin
        state_reg <= state_next;
        count_reg <= count_next;
        o_capture <= capture_next;
    end
end

endmodule // acu_sample_timer

// ### rtl/acu_regs.v
// configuration, timing and event control registers of the analog compare unit
`timescale 1ns/1ps
`include "acu_consts.vh"

////////////////////////////////////////////////////////////////////////////////
module acu_regs #(
    parameter INPUTS = 8
) (
    // clock and reset
    input wire i_ref_clk,
    input wire i_rst_n,
    // peripheral bus
    input wire [`ACU_ADDR_W-1:0] i_addr,
    input wire i_wr,
    input wire i_rd,
    input wire [7:0] i_wdata,
    output reg [7:0] o_rdata,
    // datapath events, same clock domain
    input wire i_level_burst_done,
    input wire i_compare_burst_done,
    // comparator outputs, asynchronous, high means input above threshold
    input wire [INPUTS-1:0] i_cmp_above,
    // control towards the datapath
    output reg [1:0] o_active_mode,
    output reg o_mode_start,
    output reg o_sample_capture,
    output reg [2:0] o_sampling_delay,
    output reg [1:0] o_trigger_divider,
    // event flags and interrupt
    output reg o_end_of_measurement_flag,
    output reg o_end_of_comparison_flag,
    output reg o_threshold_crossing_flag,
    output reg o_irq
);

////////////////////////////////////////////////////////////////////////////////
// declarations

reg [7:0] config_reg;
reg [7:0] timing_reg;
reg [1:0] active_mode_reg;
reg eom_flag_reg;
reg eoc_flag_reg;
reg thr_flag_reg;
reg eom_flag_next;
reg eoc_flag_next;
reg thr_flag_next;
reg [INPUTS-1:0] cmp_s1_reg;
reg [INPUTS-1:0] cmp_s2_reg;
reg [INPUTS-1:0] cmp_s3_reg;
reg [INPUTS-1:0] cmp_stable_reg;
reg [7:0] rdata_next;

wire wr_cts;
wire wr_cfg;
wire wr_tim;
wire start_req;
wire mode_change;
wire [1:0] cfg_mode;
wire timer_run;
wire capture;
wire any_above;
wire any_below;
wire cross_hit;
wire clr_eom;
wire clr_eoc;
wire clr_thr;

////////////////////////////////////////////////////////////////////////////////
// address decode

// full address compare, so neighbouring registers never alias here
assign wr_cts = i_wr && (i_addr == `ACU_OFS_CTRL_STATUS);
assign wr_cfg = i_wr && (i_addr == `ACU_OFS_CONFIG);
assign wr_tim = i_wr && (i_addr == `ACU_OFS_TIMING);

// write-one-to-clear strobes for the event flags
assign clr_eom = wr_cts && i_wdata[`ACU_CTS_EOM];
assign clr_eoc = wr_cts && i_wdata[`ACU_CTS_EOC];
assign clr_thr = wr_cts && i_wdata[`ACU_CTS_THR];

////////////////////////////////////////////////////////////////////////////////
// configuration and timing registers

// reserved bits are dropped at write time, so the read path needs no mask of its own
// configuration storage
always @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
        config_reg <= `ACU_CONFIG_RST;
        timing_reg <= `ACU_TIMING_RST;
    end else begin
        if (wr_cfg) begin
            config_reg <= i_wdata & `ACU_CONFIG_WMASK;
        end
        if (wr_tim) begin
            timing_reg <= i_wdata & `ACU_TIMING_WMASK;
        end
    end
end

assign cfg_mode = config_reg[`ACU_CFG_MODE_MSB:`ACU_CFG_MODE_LSB];

////////////////////////////////////////////////////////////////////////////////
// start trigger and active mode

// the start bit is not stored: it acts in the write cycle and reads zero
assign start_req = wr_cts && i_wdata[`ACU_CTS_START];

// a repeated start of the mode in use leaves flags and sequencer untouched
// only a different mode restarts
assign mode_change = start_req && (cfg_mode != active_mode_reg);

always @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
        active_mode_reg <= `ACU_MODE_RST;
    end else if (mode_change) begin
        active_mode_reg <= cfg_mode;
    end
end

////////////////////////////////////////////////////////////////////////////////
// comparator input synchroniser

// three stages; a bit reads above only when stages two and three are both above, and below otherwise,
// which rejects a one-cycle glitch towards above during the comparator's settle
// limitation: an above pulse shorter than two clocks is never seen, and a one-clock dip below shows for two clocks
always @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
        cmp_s1_reg <= {INPUTS{1'b0}};
        cmp_s2_reg <= {INPUTS{1'b0}};
        cmp_s3_reg <= {INPUTS{1'b0}};
        cmp_stable_reg <= {INPUTS{1'b0}};
    end else begin
        cmp_s1_reg <= i_cmp_above;
        cmp_s2_reg <= cmp_s1_reg;
        cmp_s3_reg <= cmp_s2_reg;
        cmp_stable_reg <= (cmp_stable_reg & ~(cmp_s2_reg ^ cmp_s3_reg))
            | (cmp_s2_reg & ~(cmp_s2_reg ^ cmp_s3_reg));
    end
end

////////////////////////////////////////////////////////////////////////////////
// sampling delay sequencer

// runs in every active mode; a mode change restarts its settle period
// bursts keep the sequencer running too; the datapath picks the capture it needs
assign timer_run = (active_mode_reg != `ACU_MODE_OFF);

acu_sample_timer i_acu_sample_timer (
    .i_ref_clk(i_ref_clk),
    .i_rst_n(i_rst_n),
    .i_run(timer_run),
    .i_restart(mode_change),
    .i_delay_code(timing_reg[`ACU_TIM_DELAY_MSB:`ACU_TIM_DELAY_LSB]),
    .o_capture(capture)
);

////////////////////////////////////////////////////////////////////////////////
// threshold crossing detection

// the synchroniser resets to all below; no capture comes within eleven cycles
// of a start, so that reset value never reaches a flag
assign any_above = |cmp_stable_reg;
assign any_below = |(~cmp_stable_reg);

assign cross_hit = config_reg[`ACU_CFG_POLARITY] ? any_above : any_below;

////////////////////////////////////////////////////////////////////////////////
// event flags

always @* begin
    eom_flag_next = eom_flag_reg & ~clr_eom;
    eoc_flag_next = eoc_flag_reg & ~clr_eoc;
    thr_flag_next = thr_flag_reg & ~clr_thr;
    // sets follow the clears, so an event in the clearing cycle is not lost
    // flags are set only in the mode that owns them
    if (i_level_burst_done && (active_mode_reg == `ACU_MODE_LEVEL_BURST)) begin
        eom_flag_next = 1'b1;
    end
    if (i_compare_burst_done && (active_mode_reg == `ACU_MODE_THRESH_BURST)) begin
        eoc_flag_next = 1'b1;
    end
    if (capture && cross_hit && (active_mode_reg == `ACU_MODE_LOW_POWER)) begin
        thr_flag_next = 1'b1;
    end
    // events of the old mode are stale once a new one begins
    if (mode_change) begin
        eom_flag_next = 1'b0;
        eoc_flag_next = 1'b0;
        thr_flag_next = 1'b0;
    end
end

// flag registers
always @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
        eom_flag_reg <= 1'b0;
        eoc_flag_reg <= 1'b0;
        thr_flag_reg <= 1'b0;
    end else begin
        eom_flag_reg <= eom_flag_next;
        eoc_flag_reg <= eoc_flag_next;
        thr_flag_reg <= thr_flag_next;
    end
end

////////////////////////////////////////////////////////////////////////////////
// read data

always @* begin
    rdata_next = 8'h00;
    if (i_addr == `ACU_OFS_CTRL_STATUS) begin
        rdata_next[`ACU_CTS_EOM] = eom_flag_reg;
        rdata_next[`ACU_CTS_EOC] = eoc_flag_reg;
        rdata_next[`ACU_CTS_THR] = thr_flag_reg;
    end else if (i_addr == `ACU_OFS_CONFIG) begin
        rdata_next = config_reg;
    end else if (i_addr == `ACU_OFS_TIMING) begin
        rdata_next = timing_reg;
    end
end

// read data is held between reads; unmapped addresses return zero
// reading leaves the flags alone; only a written one or a mode change clears them
always @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
        o_rdata <= 8'h00;
    end else if (i_rd) begin
        o_rdata <= rdata_next;
    end
end

////////////////////////////////////////////////////////////////////////////////
// registered outputs

// every output from a flop; the start pulse comes one cycle before the new mode shows
always @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
        o_active_mode <= `ACU_MODE_RST;
        o_mode_start <= 1'b0;
        o_sample_capture <= 1'b0;
        o_sampling_delay <= 3'h0;
        o_trigger_divider <= 2'h0;
    end else begin
        o_active_mode <= active_mode_reg;
        o_mode_start <= mode_change;
        o_sample_capture <= capture;
        o_sampling_delay <= timing_reg[`ACU_TIM_DELAY_MSB:`ACU_TIM_DELAY_LSB];
        // divider field decoding lives in the trigger path outside
        o_trigger_divider <= timing_reg[`ACU_TIM_TRIGDIV_MSB:`ACU_TIM_TRIGDIV_LSB];
    end
end

////////////////////////////////////////////////////////////////////////////////
// event outputs and interrupt

// flags and irq lag the status register by one cycle, so software that reads
// the status after seeing the irq always finds the flag that raised it
always @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
        o_end_of_measurement_flag <= 1'b0;
        o_end_of_comparison_flag <= 1'b0;
        o_threshold_crossing_flag <= 1'b0;
        o_irq <= 1'b0;
    end else begin
        o_end_of_measurement_flag <= eom_flag_reg;
        o_end_of_comparison_flag <= eoc_flag_reg;
        o_threshold_crossing_flag <= thr_flag_reg;
        // burst comparison is polled, so its flag stays out of the request
        // measurement and threshold irq enables
        o_irq <= (eom_flag_reg & config_reg[`ACU_CFG_MEAS_IRQ_EN])
            | (thr_flag_reg & config_reg[`ACU_CFG_THR_IRQ_EN]);
    end
end

endmodule // acu_regs

// ### bench/acu_regs_monitor.sv
// assertion checker watching the ports of the analog compare unit register block
`timescale 1ns/1ps
`include "acu_consts.vh"
module acu_regs_monitor #(
    parameter INPUTS = 8
) (
    // clock and reset
    input wire i_ref_clk,
    input wire i_rst_n,
    // peripheral bus
    input wire [`ACU_ADDR_W-1:0] i_addr,
    input wire i_wr,
    input wire i_rd,
    input wire [7:0] i_wdata,
    input wire [7:0] o_rdata,
    // datapath side
    input wire i_level_burst_done,
    input wire i_compare_burst_done,
    input wire [INPUTS-1:0] i_cmp_above,
    input wire [1:0] o_active_mode,
    input wire o_mode_start,
    input wire o_sample_capture,
    input wire [2:0] o_sampling_delay,
    input wire [1:0] o_trigger_divider,
    // flags and interrupt
    input wire o_end_of_measurement_flag,
    input wire o_end_of_comparison_flag,
    input wire o_threshold_crossing_flag,
    input wire o_irq
);
    reg [7:0] cfg_sh, cfg_d, tim_sh, tim_d, rmask;
    wire cts_wr = i_wr && (i_addr == `ACU_OFS_CTRL_STATUS);
    wire start_w = cts_wr && i_wdata[0];
    wire eom_clr = cts_wr && i_wdata[1];
    wire [1:0] cfg_mode = cfg_sh[1:0];
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (!i_rst_n);

    ////////////////////////////////////////////////////////////////////////////
    // shadow registers, delayed once so they line up with the registered outputs
    always @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            cfg_sh <= `ACU_CONFIG_RST;
            tim_sh <= `ACU_TIMING_RST;
        end else if (i_wr && i_addr == `ACU_OFS_CONFIG) begin
            cfg_sh <= i_wdata & `ACU_CONFIG_WMASK;
        end else if (i_wr && i_addr == `ACU_OFS_TIMING) begin
            tim_sh <= i_wdata & `ACU_TIMING_WMASK;
        end
        cfg_d <= cfg_sh;
        tim_d <= tim_sh;
    end
    // bits allowed to read as one; unmapped places read all zero
    always @* begin
        case (i_addr)
            `ACU_OFS_CTRL_STATUS: rmask = 8'h0e;
            `ACU_OFS_CONFIG: rmask = `ACU_CONFIG_WMASK;
            `ACU_OFS_TIMING: rmask = `ACU_TIMING_WMASK;
            default: rmask = 8'h00;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    a_irq_source: assert property ($past(i_rst_n) |-> o_irq ==
        ((o_end_of_measurement_flag & cfg_d[3]) | (o_threshold_crossing_flag & cfg_d[4])))
        else $error("irq does not follow the enabled flags");
    a_start_once: assert property (o_mode_start |=> !o_mode_start)
        else $error("mode start pulse longer than one cycle");
    a_mode_from_start: assert property ($changed(o_active_mode) |->
        $past(start_w, 2) && o_active_mode == $past(cfg_mode, 2))
        else $error("active mode changed without a start write");
    a_start_flags: assert property (o_mode_start |=> $changed(o_active_mode) &&
        !o_end_of_measurement_flag && !o_end_of_comparison_flag && !o_threshold_crossing_flag)
        else $error("mode start without mode change or with flags left set");
    a_capture_gap: assert property (o_mode_start |-> ##3 (!o_sample_capture) [*8])
        else $error("capture too soon after a mode start");
    a_capture_mode: assert property (o_sample_capture |-> o_active_mode != 2'h0 || $past(o_active_mode) != 2'h0)
        else $error("capture while the unit is disabled");
    a_timing_out: assert property ($past(i_rst_n) |-> o_sampling_delay == tim_d[2:0] &&
        o_trigger_divider == tim_d[5:4])
        else $error("timing outputs differ from the timing register");
    a_reserved_read: assert property ($past(i_rd) |-> (o_rdata & ~$past(rmask)) == 8'h00)
        else $error("reserved bit read as one");
    a_eom_clear: assert property ($past(eom_clr, 2) && !$past(i_level_burst_done, 2) |->
        !o_end_of_measurement_flag)
        else $error("measurement flag survived its clearing write");
endmodule // acu_regs_monitor

bind acu_regs acu_regs_monitor #(.INPUTS(INPUTS)) i_acu_regs_monitor (
    .i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wr(i_wr), .i_rd(i_rd),
    .i_wdata(i_wdata), .o_rdata(o_rdata), .i_level_burst_done(i_level_burst_done),
    .i_compare_burst_done(i_compare_burst_done), .i_cmp_above(i_cmp_above), .o_active_mode(o_active_mode),
    .o_mode_start(o_mode_start), .o_sample_capture(o_sample_capture), .o_sampling_delay(o_sampling_delay),
    .o_trigger_divider(o_trigger_divider), .o_end_of_measurement_flag(o_end_of_measurement_flag),
    .o_end_of_comparison_flag(o_end_of_comparison_flag),
    .o_threshold_crossing_flag(o_threshold_crossing_flag), .o_irq(o_irq)
);

// ### bench/acu_regs_test.sv
// self-checking bench for the analog compare unit register block
`timescale 1ns/1ps
`include "acu_consts.vh"
module acu_regs_test;
    logic clk, rst_n, wr, rd, lvl, cmpd, rd_d1, rd_d2;
    logic [23:0] addr;
    logic [7:0] wdata, cmp, r;
    logic [7:0] exp_q[$];
    wire [7:0] rdata;
    wire [1:0] mode, tdiv;
    wire [2:0] sdly;
    wire start, cap, eom, eoc, thr, irq;
    int fail_count, comparisons, n, k, starts;
    int sc[8] = '{11, 16, 22, 27, 32, 37, 48, 58};

    acu_regs #(.INPUTS(8)) i_acu_regs (
        .i_ref_clk(clk), .i_rst_n(rst_n), .i_addr(addr), .i_wr(wr), .i_rd(rd), .i_wdata(wdata),
        .o_rdata(rdata), .i_level_burst_done(lvl), .i_compare_burst_done(cmpd), .i_cmp_above(cmp),
        .o_active_mode(mode), .o_mode_start(start), .o_sample_capture(cap), .o_sampling_delay(sdly),
        .o_trigger_divider(tdiv), .o_end_of_measurement_flag(eom), .o_end_of_comparison_flag(eoc),
        .o_threshold_crossing_flag(thr), .o_irq(irq)
    );

    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [7:0] got, input logic [7:0] want);
        comparisons++;
        if (got !== want) begin
            fail_count++;
            $display("CHECK FAILED at %0t: got %h want %h", $time, got, want);
        end
    endtask
    task automatic wr_reg(input logic [23:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    // reads only note what they expect; spaced so read data is never overwritten
    task automatic rd_reg(input logic [23:0] a, input logic [7:0] want);
        exp_q.push_back(want);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        repeat (2) @(posedge clk);
    endtask
    task automatic pulse(input logic which);
        @(posedge clk);
        lvl <= !which;
        cmpd <= which;
        @(posedge clk);
        lvl <= 1'b0;
        cmpd <= 1'b0;
        repeat (3) @(posedge clk);
    endtask
    task automatic start_mode(input logic [1:0] m, input logic [7:0] cfg);
        wr_reg(`ACU_OFS_CONFIG, cfg | {6'h0, m});
        wr_reg(`ACU_OFS_CTRL_STATUS, 8'h01);
        repeat (3) @(posedge clk);
    endtask
    // bounded wait for a capture pulse; cnt of 100 means none came
    task automatic wait_cap(output int cnt);
        cnt = 0;
        @(posedge clk);
        while (cap !== 1'b1 && cnt < 100) begin
            @(posedge clk);
            cnt++;
        end
    endtask
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // read watcher: takes the oldest note two edges after the read is taken
    always @(posedge clk) begin
        if (rd_d2)
            chk(rdata, exp_q.pop_front());
        // each one-cycle start pulse is counted once
        if (start === 1'b1)
            starts++;
        rd_d2 <= rd_d1;
        rd_d1 <= rd;
    end
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    // watchdog at 8000 cycles, well beyond the roughly 1200 cycles the run needs
    initial begin
        #200000;
        fail_count++;
        complete_run();
    end

    initial begin
        rst_n = 1'b0;
        wr = 1'b0;
        rd = 1'b0;
        lvl = 1'b0;
        cmpd = 1'b0;
        addr = 24'h000000;
        wdata = 8'h00;
        cmp = 8'hff;
        rd_d1 = 1'b0;
        rd_d2 = 1'b0;
        r = 8'($urandom(91));
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        rd_reg(`ACU_OFS_CONFIG, 8'h00);
        rd_reg(`ACU_OFS_TIMING, 8'h37);
        rd_reg(`ACU_OFS_CTRL_STATUS, 8'h00);
        // random writes: reserved bits drop, mode waits for start
        for (k = 0; k < 4; k++) begin
            r = 8'($urandom);
            wr_reg(`ACU_OFS_CONFIG, r);
            rd_reg(`ACU_OFS_CONFIG, r & 8'h3b);
            wr_reg(`ACU_OFS_TIMING, r);
            rd_reg(`ACU_OFS_TIMING, r & 8'h37);
            chk({3'h0, tdiv, sdly}, {3'h0, r[5:4], r[2:0]});
            chk({6'h0, mode}, 8'h00);
        end
        wr_reg(24'h00fd46, 8'hff);
        rd_reg(24'h00fd46, 8'h00);
        // every mode code through a start
        for (k = 1; k < 5; k++) begin
            start_mode(k[1:0], 8'h00);
            chk({6'h0, mode}, {6'h0, k[1:0]});
        end
        // measurement flag, enable, restart and clear
        start_mode(2'h1, 8'h00);
        pulse(1'b0);
        chk({7'h0, irq}, 8'h00);
        rd_reg(`ACU_OFS_CTRL_STATUS, 8'h02);
        chk({4'h0, thr, eoc, eom, 1'b0}, 8'h02);
        wr_reg(`ACU_OFS_CONFIG, 8'h09);
        repeat (3) @(posedge clk);
        chk({7'h0, irq}, 8'h01);
        start_mode(2'h1, 8'h08);
        rd_reg(`ACU_OFS_CTRL_STATUS, 8'h02);
        wr_reg(`ACU_OFS_CTRL_STATUS, 8'h02);
        repeat (3) @(posedge clk);
        chk({7'h0, irq}, 8'h00);
        pulse(1'b0);
        start_mode(2'h2, 8'h18);
        rd_reg(`ACU_OFS_CTRL_STATUS, 8'h00);
        chk({4'h0, thr, eoc, eom, 1'b0}, 8'h00);
        pulse(1'b1);
        rd_reg(`ACU_OFS_CTRL_STATUS, 8'h04);
        chk({4'h0, thr, eoc, eom, 1'b0}, 8'h04);
        chk({7'h0, irq}, 8'h00);
        // polarity in low-power compare, shortest delay code
        wr_reg(`ACU_OFS_TIMING, 8'h30);
        start_mode(2'h3, 8'h10);
        repeat (2) wait_cap(n);
        rd_reg(`ACU_OFS_CTRL_STATUS, 8'h00);
        cmp <= 8'hfe;
        repeat (2) wait_cap(n);
        rd_reg(`ACU_OFS_CTRL_STATUS, 8'h08);
        chk({4'h0, thr, eoc, eom, 1'b0}, 8'h08);
        chk({7'h0, irq}, 8'h01);
        cmp <= 8'h00;
        wr_reg(`ACU_OFS_CONFIG, 8'h33);
        repeat (2) wait_cap(n);
        wr_reg(`ACU_OFS_CTRL_STATUS, 8'h08);
        repeat (2) wait_cap(n);
        rd_reg(`ACU_OFS_CTRL_STATUS, 8'h00);
        chk({7'h0, irq}, 8'h00);
        wr_reg(`ACU_OFS_CONFIG, 8'h23);
        cmp <= 8'h10;
        repeat (2) wait_cap(n);
        rd_reg(`ACU_OFS_CTRL_STATUS, 8'h08);
        chk({7'h0, irq}, 8'h00);
        // capture spacing per delay code: settle, compare, then one idle cycle
        for (k = 0; k < 8; k++) begin
            wr_reg(`ACU_OFS_TIMING, 8'h30 | 8'(k));
            repeat (3) wait_cap(n);
            chk({7'h0, n == sc[k]}, 8'h01);
        end
        start_mode(2'h0, 8'h00);
        repeat (4) @(posedge clk);
        wait_cap(n);
        chk({7'h0, n == 100}, 8'h01);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        rd_reg(`ACU_OFS_TIMING, 8'h37);
        rd_reg(`ACU_OFS_CONFIG, 8'h00);
        repeat (4) @(posedge clk);
        chk(8'(starts), 8'h08);
        complete_run();
    end
endmodule // acu_regs_test
